// File: rtl/timer_capture_pkg.sv
// Overview of operation
// RL1: Free-running: each valid edge on input A copies count into register B, raises B.
// RL2: Pins sampled on count clock; edge accepted only after two equal samples.
// RL3: Input A valid edge chosen by prescaler bits 4-5: rising, falling or both.
// RL4: Input B valid edge chosen independently by prescaler bits 6-7.
// RL5: Valid edge on input B copies count into register A, raises interrupt A.
// RL6: Two-capture mode: edge of A opposite to B-capture edge loads register A.
// RL7: With both A edges valid, register A does no opposite-edge capture.
// RL8: Source select 1: B edge leaves register A unchanged but still raises interrupt A.
// RL9: Restart mode: valid A edge captures count into B, then clears counter.
// RL10: Counter wrap while running sets the wrap flag.
// RL11: Measurement covers one counter cycle only; no count extension.
// RL12: Output enabled with toggle-on-match inverts pin every compare value plus one counts.
// RL13: Software loads a nonzero compare value before square-wave output.
// RL14: Software configures prescaler, capture control, output, compare, then mode.
// RL15: Software avoids rewriting compare value while counter runs.
// RL16: Count clock chosen by prescaler bits 0-1.
// RL17: Clear-on-match: count equal to register A clears counter, raises interrupt A.
// RL18: Counter runs while operation bits are not 00, stops at 00.
// RL19: Free-running counter increments each count clock, wraps to zero, ignores compare.
package timer_capture_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_PRESCALE   = 8'h00;
  localparam logic [7:0] OFS_CAPCMP_CTL = 8'h04;
  localparam logic [7:0] OFS_OUTPUT_CTL = 8'h08;
  localparam logic [7:0] OFS_MODE_CTL   = 8'h0C;
  localparam logic [7:0] OFS_REG_A      = 8'h10;
  localparam logic [7:0] OFS_REG_B      = 8'h14;
  localparam logic [7:0] OFS_COUNT      = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h20;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CAP_A_EN_BIT   = 0;
  localparam int CAP_SRC_BIT    = 1;
  localparam int OUT_EN_BIT     = 0;
  localparam int TOGGLE_BIT     = 1;
  localparam int OP_MODE_LO_BIT = 2;
  localparam int IRQ_A_BIT      = 0;
  localparam int IRQ_B_BIT      = 1;
  localparam int IRQ_WRAP_BIT   = 2;

  // ************************************************************
  // Encodings and reset values
  // ************************************************************
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_NONE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Prescaler divide masks for count clock selects 0..3 (1, 2, 4, 8)
  localparam logic [2:0] DIV_MASK_0 = 3'h0;
  localparam logic [2:0] DIV_MASK_1 = 3'h1;
  localparam logic [2:0] DIV_MASK_2 = 3'h3;
  localparam logic [2:0] DIV_MASK_3 = 3'h7;

  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [1:0] CTRL2_RST    = 2'h0;
  localparam logic [2:0] IRQ_RST      = 3'h0;

  typedef enum logic [1:0] {
    MODE_STOP    = 2'h0,
    MODE_FREE    = 2'h1,
    MODE_RESTART = 2'h2,
    MODE_MATCH   = 2'h3
  } op_mode_e;

  typedef struct packed {
    logic [1:0] edge_b_sel;
    logic [1:0] edge_a_sel;
    logic [1:0] spare;
    logic [1:0] clk_sel;
  } prescale_s;

endpackage

// File: rtl/timer_capture_square_wave.sv
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
module timer_capture_square_wave #(
  parameter int CNT_W = 16
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        timer_input_a,
  input  wire logic        timer_input_b,
  output logic             timer_output_pin,
  output logic             irq
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 2 and 32");
  end

  // ************************************************************
  // State
  // ************************************************************
  timer_capture_pkg::prescale_s prescale_ctrl;
  timer_capture_pkg::op_mode_e  op_mode;
  logic [1:0]       capcmp_ctrl;
  logic [1:0]       output_ctrl;
  logic [CNT_W-1:0] capcmp_reg_a;
  logic [CNT_W-1:0] capcmp_reg_b;
  logic [CNT_W-1:0] timer_count;
  logic [2:0]       irq_status;
  logic [2:0]       irq_mask;
  logic [2:0]       div_cnt;
  logic [1:0][1:0]  smp;
  logic [1:0]       flt;
  logic             wr_q;
  logic [7:0]       addr_q;
  logic [2:0]       div_mask;
  logic             tick;
  logic [1:0]       rise;
  logic [1:0]       fall;
  logic             run;
  logic             valid_a;
  logic             valid_b;
  logic             opp_a;
  logic             match;
  logic             restart_ev;
  logic             wrap_ev;
  logic             cap_a_en;
  logic             cap_src;
  logic             load_a;
  logic [2:0]       irq_ev;
  logic [2:0]       next_irq_status;
  logic             addr_ph;
  logic [31:0]      rd_val;
  // True when the data phase is a write to the given register
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_q && (addr_q == ofs);
  endfunction
  // Valid-edge test for one input against its edge select
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    unique case (sel)
      timer_capture_pkg::EDGE_FALL: edge_hit = f;
      timer_capture_pkg::EDGE_RISE: edge_hit = r;
      timer_capture_pkg::EDGE_BOTH: edge_hit = r | f;
      default:                      edge_hit = 1'b0;
    endcase
  endfunction

  // ************************************************************
  // Count clock prescaler
  // ************************************************************
  // Divider runs free; the select only masks it, so switching is glitch free
  always_comb begin
    unique case (prescale_ctrl.clk_sel)
      2'h0: div_mask = timer_capture_pkg::DIV_MASK_0;
      2'h1: div_mask = timer_capture_pkg::DIV_MASK_1;
      2'h2: div_mask = timer_capture_pkg::DIV_MASK_2;
      default: div_mask = timer_capture_pkg::DIV_MASK_3;
    endcase
  end
  assign tick = ((div_cnt & div_mask) == 3'h0); // [RL16]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // ************************************************************
  // Input sampling and two-sample filter
  // ************************************************************
  // Pins are synchronous, so the sample chain doubles as the noise filter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp <= '0;
      flt <= 2'h0;
    end else if (tick) begin
      smp[0] <= {smp[0][0], timer_input_a};
      smp[1] <= {smp[1][0], timer_input_b};
      for (int i = 0; i < 2; i++) begin
        if (smp[i][1] == smp[i][0]) begin
          flt[i] <= smp[i][0]; // [RL2]
        end
      end
    end
  end

  // Edge only once two consecutive samples agree on the new level
  for (genvar g = 0; g < 2; g++) begin : g_edge
    assign rise[g] = tick && (smp[g] == 2'h3) && !flt[g]; // [RL2]
    assign fall[g] = tick && (smp[g] == 2'h0) && flt[g];  // [RL2]
  end

  // ************************************************************
  // Event decode
  // ************************************************************
  assign run      = (op_mode != timer_capture_pkg::MODE_STOP); // [RL18]
  assign cap_a_en = capcmp_ctrl[timer_capture_pkg::CAP_A_EN_BIT];
  assign cap_src  = capcmp_ctrl[timer_capture_pkg::CAP_SRC_BIT];
  assign valid_a  = run && edge_hit(prescale_ctrl.edge_a_sel, rise[0], fall[0]); // [RL3]
  assign valid_b  = run && edge_hit(prescale_ctrl.edge_b_sel, rise[1], fall[1]); // [RL4]
  // Opposite edge exists only for a single-edge select
  assign opp_a = run && (((prescale_ctrl.edge_a_sel == timer_capture_pkg::EDGE_FALL) && rise[0])
                 || ((prescale_ctrl.edge_a_sel == timer_capture_pkg::EDGE_RISE) && fall[0])); // [RL7]
  assign match = run && tick && (op_mode == timer_capture_pkg::MODE_MATCH)
                 && (timer_count == capcmp_reg_a); // [RL17]
  assign restart_ev = valid_a && (op_mode == timer_capture_pkg::MODE_RESTART); // [RL9]
  // No extension counter: a wrap only flags, width is one counter cycle
  assign wrap_ev = run && tick && (timer_count == {CNT_W{1'b1}})
                   && !restart_ev && !match; // [RL10] [RL11]
  assign load_a = cap_a_en && ((!cap_src && valid_b) || (cap_src && opp_a)); // [RL5] [RL6] [RL8]

  // ************************************************************
  // Counter
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_count <= '0;
    end else if (!run) begin
      timer_count <= '0; // [RL18]
    end else if (restart_ev || match) begin
      timer_count <= '0; // [RL9] [RL17]
    end else if (tick) begin
      timer_count <= CNT_W'(timer_count + 1'b1); // [RL19]
    end
  end

  // ************************************************************
  // Capture and compare registers
  // ************************************************************
  // Register B captures the count that stood when input A's edge came
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capcmp_reg_b <= '0;
    end else if (valid_a) begin
      capcmp_reg_b <= timer_count; // [RL1] [RL9]
    end
  end

  // Software writes are ignored while register A serves as a capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capcmp_reg_a <= '0;
    end else if (load_a) begin
      capcmp_reg_a <= timer_count; // [RL5] [RL6]
    end else if (wr_hit(timer_capture_pkg::OFS_REG_A) && !cap_a_en) begin
      capcmp_reg_a <= hwdata[CNT_W-1:0];
    end
  end

  // ************************************************************
  // Square-wave output
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_output_pin <= 1'b0;
    end else if (!output_ctrl[timer_capture_pkg::OUT_EN_BIT]) begin
      timer_output_pin <= 1'b0;
    end else if (match && output_ctrl[timer_capture_pkg::TOGGLE_BIT]) begin
      timer_output_pin <= !timer_output_pin; // [RL12]
    end
  end

  // ************************************************************
  // Interrupt status, mask and output
  // ************************************************************
  always_comb begin
    irq_ev = 3'h0;
    irq_ev[timer_capture_pkg::IRQ_A_BIT]    = match || (cap_a_en && valid_b); // [RL5] [RL8] [RL17]
    irq_ev[timer_capture_pkg::IRQ_B_BIT]    = valid_a; // [RL1]
    irq_ev[timer_capture_pkg::IRQ_WRAP_BIT] = wrap_ev; // [RL10]
    next_irq_status = irq_status;
    if (wr_hit(timer_capture_pkg::OFS_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~hwdata[2:0];
    end
    // A new event outweighs a clear in the same cycle
    next_irq_status = next_irq_status | irq_ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= timer_capture_pkg::IRQ_RST;
      irq       <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq       <= |(irq_status & irq_mask);
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_ctrl <= timer_capture_pkg::PRESCALE_RST;
      capcmp_ctrl   <= timer_capture_pkg::CTRL2_RST;
      output_ctrl   <= timer_capture_pkg::CTRL2_RST;
      op_mode       <= timer_capture_pkg::MODE_STOP;
      irq_mask      <= timer_capture_pkg::IRQ_RST;
    end else begin
      if (wr_hit(timer_capture_pkg::OFS_PRESCALE)) begin
        prescale_ctrl <= hwdata[7:0];
      end
      if (wr_hit(timer_capture_pkg::OFS_CAPCMP_CTL)) begin
        capcmp_ctrl <= hwdata[1:0];
      end
      if (wr_hit(timer_capture_pkg::OFS_OUTPUT_CTL)) begin
        output_ctrl <= hwdata[1:0];
      end
      if (wr_hit(timer_capture_pkg::OFS_MODE_CTL)) begin
        op_mode <= timer_capture_pkg::op_mode_e'(
                   hwdata[timer_capture_pkg::OP_MODE_LO_BIT +: 2]); // [RL18]
      end
      if (wr_hit(timer_capture_pkg::OFS_IRQ_MASK)) begin
        irq_mask <= hwdata[2:0];
      end
    end
  end

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  assign addr_ph = hsel && htrans[1] && hready;
  // Read data is fetched in the address phase so it leaves a flip-flop
  always_comb begin
    rd_val = 32'h0;
    unique case (haddr[7:0])
      timer_capture_pkg::OFS_PRESCALE:   rd_val = 32'(prescale_ctrl);
      timer_capture_pkg::OFS_CAPCMP_CTL: rd_val = 32'(capcmp_ctrl);
      timer_capture_pkg::OFS_OUTPUT_CTL: rd_val = 32'(output_ctrl);
      timer_capture_pkg::OFS_MODE_CTL:   rd_val = 32'({op_mode, 2'h0});
      timer_capture_pkg::OFS_REG_A:      rd_val = 32'(capcmp_reg_a);
      timer_capture_pkg::OFS_REG_B:      rd_val = 32'(capcmp_reg_b);
      timer_capture_pkg::OFS_COUNT:      rd_val = 32'(timer_count);
      timer_capture_pkg::OFS_IRQ_STATUS: rd_val = 32'(irq_status);
      timer_capture_pkg::OFS_IRQ_MASK:   rd_val = 32'(irq_mask);
      default:                           rd_val = 32'h0;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      addr_q    <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_q      <= addr_ph && hwrite;
      addr_q    <= haddr[7:0];
      hrdata    <= (addr_ph && !hwrite) ? rd_val : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_cap_b;
    valid_a |=> capcmp_reg_b == $past(timer_count) && irq_status[1];
  endproperty
  a_cap_b: assert property (p_cap_b) else $error("capture B missed"); // [RL1]
  property p_filter;
    (rise[0] || fall[0]) |-> tick && smp[0][1] == smp[0][0] && flt[0] != smp[0][0];
  endproperty
  a_filter: assert property (p_filter) else $error("edge without two samples"); // [RL2]
  property p_cap_a;
    (cap_a_en && !cap_src && valid_b) |=> capcmp_reg_a == $past(timer_count) && irq_status[0];
  endproperty
  a_cap_a: assert property (p_cap_a) else $error("capture A missed"); // [RL5]
  property p_src_sel;
    (cap_a_en && cap_src && valid_b && !opp_a) |=> $stable(capcmp_reg_a) && irq_status[0];
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("source select broken"); // [RL8]
  property p_both;
    (prescale_ctrl.edge_a_sel == timer_capture_pkg::EDGE_BOTH) |-> !opp_a;
  endproperty
  a_both: assert property (p_both) else $error("opposite edge with both edges"); // [RL7]
  property p_restart;
    restart_ev |=> timer_count == '0 ##1 (!tick || !run || timer_count <= 1);
  endproperty
  a_restart: assert property (p_restart) else $error("restart not cleared"); // [RL9]
  property p_wrap;
    wrap_ev |=> timer_count == '0 && irq_status[2];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag missed"); // [RL10]
  property p_toggle;
    (match && output_ctrl == 2'h3) |=> timer_output_pin != $past(timer_output_pin);
  endproperty
  a_toggle: assert property (p_toggle) else $error("square wave not toggled"); // [RL12]
  property p_match;
    match |=> timer_count == '0 && irq_status[0];
  endproperty
  a_match: assert property (p_match) else $error("match clear missed"); // [RL17]
  property p_stop;
    !run |=> timer_count == '0 && !irq_status[1] || $past(irq_status[1]);
  endproperty
  a_stop: assert property (p_stop) else $error("counter ran while stopped"); // [RL18]
  property p_free;
    (tick && op_mode == timer_capture_pkg::MODE_FREE) |=>
      timer_count == CNT_W'($past(timer_count) + 1'b1);
  endproperty
  a_free: assert property (p_free) else $error("free-run count wrong"); // [RL19]
endmodule

// File: verification/pulse_source.sv
`timescale 1ns/10ps
// ************************************************************
// Pulse source standing on the timer input pins
// ************************************************************
module pulse_source (
  input  wire logic hclk,
  output logic      timer_input_a,
  output logic      timer_input_b
);
  // Pins idle low; they are driven levels, never released
  initial begin
    timer_input_a = 1'b0;
    timer_input_b = 1'b0;
  end

  // Change just after an edge; bit 0 of ch is pin A, bit 1 is pin B
  task automatic drive(input logic [1:0] ch, input logic lvl);
    @(posedge hclk);
    if (ch[0]) begin
      timer_input_a <= lvl;
    end
    if (ch[1]) begin
      timer_input_b <= lvl;
    end
  endtask

  // High for w cycles; a width of 1 is a glitch below the filter
  task automatic pulse(input logic [1:0] ch, input int w);
    drive(ch, 1'b1);
    repeat (w - 1) @(posedge hclk);
    drive(ch, 1'b0);
  endtask
endmodule

// File: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // ************************************************************
  // Signals and constants
  // ************************************************************
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        timer_input_a;
  logic        timer_input_b;
  logic        timer_output_pin;
  logic        irq;
  logic        rd_pend;
  logic [31:0] rd_last;
  logic [31:0] seed;
  logic [71:0] note;
  logic [71:0] notes[$];
  int          mismatches;
  int          n_compared;
  localparam int          CW    = 8;
  localparam logic [31:0] CMASK = (32'h1 << CW) - 32'h1;
  localparam logic [7:0]  PRE   = timer_capture_pkg::OFS_PRESCALE;
  localparam logic [7:0]  CC    = timer_capture_pkg::OFS_CAPCMP_CTL;
  localparam logic [7:0]  OC    = timer_capture_pkg::OFS_OUTPUT_CTL;
  localparam logic [7:0]  MC    = timer_capture_pkg::OFS_MODE_CTL;
  localparam logic [7:0]  RA    = timer_capture_pkg::OFS_REG_A;
  localparam logic [7:0]  RB    = timer_capture_pkg::OFS_REG_B;
  localparam logic [7:0]  ST    = timer_capture_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0]  MSK   = timer_capture_pkg::OFS_IRQ_MASK;
  localparam logic [31:0] FREE  = 32'({timer_capture_pkg::MODE_FREE, 2'h0});
  localparam logic [31:0] RSTRT = 32'({timer_capture_pkg::MODE_RESTART, 2'h0});
  localparam logic [31:0] MATCH = 32'({timer_capture_pkg::MODE_MATCH, 2'h0});

  // Counter narrowed so that a wrap comes within a few hundred ticks
  timer_capture_square_wave #(.CNT_W(CW)) u_timer_capture_square_wave (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer_input_a(timer_input_a), .timer_input_b(timer_input_b),
    .timer_output_pin(timer_output_pin), .irq(irq)
  );
  pulse_source u_pulse_source (
    .hclk(hclk), .timer_input_a(timer_input_a), .timer_input_b(timer_input_b)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Fixed seed keeps every run identical
  function automatic int rnd(input int span);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return int'(seed % 32'(span));
  endfunction

  // Bounded wait for hready; slave latency is never assumed
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n == 50) check("hready wait", 32'(n), 32'h0);
  endtask

  // One single AHB transfer; a read leaves a note with mask and expectation
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_ready();
    hsel    <= 1'b0;
    htrans  <= 2'h0;
    hwdata  <= d;
    rd_pend <= ~w;
    if (!w) notes.push_back({a, m, d});
    wait_ready();
    rd_pend <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, e, m);
  endtask

  task automatic get(input logic [7:0] a, output logic [31:0] v);
    xfer(1'b0, a, 32'h0, 32'h0);
    v = rd_last;
  endtask

  // Pulse on pin A; the second capture register is read while it is high
  task automatic apulse(input int w, output logic [31:0] rb);
    fork
      u_pulse_source.pulse(2'h1, w);
      begin
        repeat (6) @(posedge hclk);
        get(RB, rb);
      end
    join
    repeat (6) @(posedge hclk);
  endtask

  // Cycles between two toggles of the output pin
  task automatic gap(output int n);
    logic p;
    n = 0;
    p = timer_output_pin;
    while (timer_output_pin === p && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    p = timer_output_pin;
    n = 0;
    while (timer_output_pin === p && n < 2000) begin
      @(posedge hclk);
      n++;
    end
  endtask

  // ************************************************************
  // Clock, result monitor, watchdog
  // ************************************************************
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Oldest note is taken when a read data phase completes
  always @(posedge hclk) begin
    if (rd_pend === 1'b1 && hreadyout === 1'b1) begin
      note = notes.pop_front();
      rd_last = hrdata;
      if (note[63:32] != 32'h0) begin
        check($sformatf("reg %h", note[71:64]), hrdata & note[63:32], note[31:0]);
      end
    end
  end

  // Whole run takes under ten thousand cycles
  initial begin
    repeat (40000) @(posedge hclk);
    mismatches++;
    $display("mismatch watchdog expected finished seen running");
    summarize();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [31:0] r1;
    logic [31:0] r2;
    logic [31:0] bv;
    int          w;
    int          n;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_pend = 1'b0;
    seed = 32'hBC850E32;
    mismatches = 0;
    n_compared = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 10; i++) rd(8'(i * 4), 32'h0, 32'hFFFFFFFF);
    check("hresp", {31'h0, hresp}, 32'h0);
    wr(8'h24, 32'hFFFFFFFF);
    rd(8'h24, 32'h0, 32'hFFFFFFFF);
    wr(RB, 32'hFFFFFFFF);
    rd(RB, 32'h0, 32'hFFFFFFFF);
    wr(OC, 32'hFFFFFFFF);
    rd(OC, 32'h3, 32'hFFFFFFFF);
    wr(OC, 32'h0);
    $display("test registers done");
    // Every edge code on both pins; c * 0x50 sets both fields at once
    wr(CC, 32'h1);
    wr(MC, FREE);
    for (int c = 0; c < 4; c++) begin
      wr(PRE, 32'(c * 8'h50));
      for (int ch = 1; ch < 3; ch++) begin
        bv = (ch == 1) ? 32'h2 : 32'h1;
        wr(ST, 32'h7);
        u_pulse_source.drive(2'(ch), 1'b1);
        repeat (6) @(posedge hclk);
        rd(ST, c[0] ? bv : 32'h0, bv);
        wr(ST, 32'h7);
        u_pulse_source.drive(2'(ch), 1'b0);
        repeat (6) @(posedge hclk);
        rd(ST, (c[0] == c[1]) ? bv : 32'h0, bv);
      end
    end
    $display("test edge select done");
    // Same edge on both pins lands the same count in both registers
    wr(PRE, 32'h50);
    u_pulse_source.drive(2'h3, 1'b1);
    repeat (6) @(posedge hclk);
    get(RA, r1);
    rd(RB, r1 & CMASK, CMASK);
    u_pulse_source.drive(2'h3, 1'b0);
    wr(ST, 32'h7);
    u_pulse_source.pulse(2'h1, 1);
    repeat (6) @(posedge hclk);
    rd(ST, 32'h0, 32'h2);
    wr(PRE, 32'h30);
    w = 40 + rnd(64);
    apulse(w, r1);
    rd(RB, (r1 + 32'(w)) & CMASK, CMASK);
    $display("test free run capture done");
    // Restart: equal widths give equal captures
    wr(MC, RSTRT);
    apulse(w, r1);
    get(RB, r2);
    check("restart width", r2, 32'(w - 1));
    repeat (20) @(posedge hclk);
    apulse(w, r1);
    rd(RB, r2, CMASK);
    wr(MC, FREE);
    wr(CC, 32'h3);
    wr(PRE, 32'h50);
    apulse(w, r1);
    rd(RA, (r1 + 32'(w)) & CMASK, CMASK);
    wr(ST, 32'h7);
    u_pulse_source.pulse(2'h2, 20);
    repeat (6) @(posedge hclk);
    rd(RA, (r1 + 32'(w)) & CMASK, CMASK);
    rd(ST, 32'h1, 32'h1);
    wr(PRE, 32'h70);
    apulse(w + 5, r2);
    rd(RA, (r1 + 32'(w)) & CMASK, CMASK);
    $display("test two capture done");
    // Interrupt raised, masked and cleared
    wr(CC, 32'h0);
    wr(PRE, 32'h10);
    wr(MSK, 32'h0);
    wr(ST, 32'h7);
    apulse(20, r1);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(MSK, 32'h2);
    repeat (2) @(posedge hclk);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    wr(ST, 32'h2);
    repeat (2) @(posedge hclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd(ST, 32'h0, 32'h2);
    wr(ST, 32'h7);
    repeat (300) @(posedge hclk);
    rd(ST, 32'h4, 32'h4);
    wr(MC, 32'h0);
    rd(timer_capture_pkg::OFS_COUNT, 32'h0, CMASK);
    wr(ST, 32'h7);
    apulse(20, r1);
    rd(ST, 32'h0, 32'h7);
    $display("test interrupt and stop done");
    // Square wave for every count clock, configured in the safe order
    for (int s = 0; s < 4; s++) begin
      wr(MC, 32'h0);
      n = 2 + rnd(8);
      wr(PRE, 32'(s));
      wr(CC, 32'h0);
      wr(OC, 32'h3);
      wr(RA, 32'(n));
      wr(ST, 32'h7);
      wr(MC, MATCH);
      gap(w);
      check("toggle gap", 32'(w), 32'((n + 1) << s));
      rd(ST, 32'h1, 32'h1);
    end
    wr(OC, 32'h0);
    repeat (2) @(posedge hclk);
    check("pin disabled", {31'h0, timer_output_pin}, 32'h0);
    $display("test square wave done");
    summarize();
  end
endmodule
